/* rtl/dcd_lane_merge.sv */
// Purpose : merge one byte lane of a write beat with the stored byte
// Assumes : mask high means keep the stored byte
// Notes   : purely combinational, one instance per lane
`timescale 1ns/1ps
`default_nettype none
module dcd_lane_merge
    import dcd_pkg::*;
#(
    parameter int W = LANE_W
)(
    // stored and incoming lane
    input  wire logic [W-1:0] old_i,
    input  wire logic [W-1:0] new_i,
    // lane mask for this beat
    input  wire logic         mask_i,
    // lane value to store
    output logic [W-1:0]      merged_o
);
    // masked beat keeps the old byte
    assign merged_o = mask_i ? old_i : new_i;
endmodule
`default_nettype wire

/* rtl/dcd_pkg.sv */
// Purpose : constants and types for the ddr2 command/address input decode
// Assumes : one clock_i rising edge stands for one true-clock rising edge
// Notes   : termination enable bits in the extended mode word are local picks
//
// Behaviour
// - registered cke high enables internal clocking, low disables it
// - cke low, all idle: precharge power-down or self refresh; else active
// - cke sampled on clock for entries; self-refresh exit seen without clock
// - power-down ignores every input except clock, cke and termination input
// - self refresh ignores every input except cke, clock included
// - command decoder works only when chip select is registered low
// - command is the four-bit code of select, row, column and write strobes
// - write beat with its mask high leaves the stored lane unchanged
// - mask is sampled once per write data beat, both strobe edges
// - lower mask guards bits 7..0, upper mask bits 15..8, independently
// - bank address picks the bank for activate, read, write, precharge
// - bank address picks which of four mode registers a load writes
// - address gives row on activate, column on read/write; bit 10 auto-close
// - precharge closes the addressed bank if bit 10 low, all banks if high
// - load mode stores the address inputs as the op-code
// - data bus is 16 bits wide, or 8 bits in the narrow organisation
// - address and control are registered only on the true clock rising edge
// - termination follows registered odt unless disabled by mode load
package dcd_pkg;
    // array shape
    localparam int BANKS         = 4;
    localparam int BA_W          = 2;
    localparam int ADDR_W        = 13;
    localparam int LANE_W        = 8;
    localparam int DQ_W_DEF      = 16;
    localparam int BURST_LEN_DEF = 4;
    localparam int COL_BITS_DEF  = 3;
    localparam int CMD_W         = 4;

    // address field positions
    localparam int AP_BIT     = 10;
    localparam int RTT_LO_BIT = 2;
    localparam int RTT_HI_BIT = 6;

    // mode register holding the termination enable
    localparam logic [BA_W-1:0] EMR_SEL = 2'h1;

    // reset values
    localparam logic [ADDR_W-1:0] MODE_RST = 13'h0000;
    localparam logic [ADDR_W-1:0] ROW_RST  = 13'h0000;

    // command codes as {cs_n, ras_n, cas_n, we_n}
    localparam logic [CMD_W-1:0] CMD_LOAD_MODE = 4'h0;
    localparam logic [CMD_W-1:0] CMD_REFRESH   = 4'h1;
    localparam logic [CMD_W-1:0] CMD_PRECHARGE = 4'h2;
    localparam logic [CMD_W-1:0] CMD_ACTIVE    = 4'h3;
    localparam logic [CMD_W-1:0] CMD_WRITE     = 4'h4;
    localparam logic [CMD_W-1:0] CMD_READ      = 4'h5;

    // command and address pins sampled together
    typedef struct packed {
        logic              cs_n;
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic [BA_W-1:0]   ba;
        logic [ADDR_W-1:0] addr;
    } dcd_cmd_pins_t;

    // clocked power states; self refresh is held apart
    typedef enum logic [1:0] {
        PWR_ACTIVE,
        PWR_PRE_PD,
        PWR_ACT_PD
    } dcd_pwr_t;
endpackage

/* rtl/dcd_top.sv */
// Purpose : command, address, cke and mask input side of a four-bank ddr2
// Assumes : inputs synchronous to clock_i; beats arrive on wr_beat_i
// Notes   : storage is a small bank/column array, rows are only tracked
`timescale 1ns/1ps
`default_nettype none
module dcd_top
    import dcd_pkg::*;
#(
    parameter int DQ_W      = DQ_W_DEF,
    parameter int BURST_LEN = BURST_LEN_DEF,
    parameter int COL_BITS  = COL_BITS_DEF
)(
    // clock and reset
    input  wire logic                      clock_i,
    input  wire logic                      sys_rst_i,
    // control pins
    input  wire logic                      cke_i,
    input  wire logic                      odt_i,
    input  wire dcd_cmd_pins_t             cmd_pins_i,
    // write beats, one per strobe edge
    input  wire logic                      wr_beat_i,
    input  wire logic [DQ_W-1:0]           dq_i,
    input  wire logic [DQ_W/LANE_W-1:0]    dm_i,
    // data pin drive side
    output logic [DQ_W-1:0]                dq_o,
    output logic                           dq_oe_o,
    // visible state
    output logic                           clk_en_o,
    output var dcd_pwr_t                   pwr_state_o,
    output logic                           self_refresh_o,
    output logic                           cmd_accept_o,
    output logic [CMD_W-1:0]               cmd_code_o,
    output logic [BANKS-1:0]               bank_open_o,
    output logic [BANKS-1:0][ADDR_W-1:0]   open_row_o,
    output logic [BANKS-1:0][ADDR_W-1:0]   mode_reg_o,
    output logic                           odt_term_o
);
    localparam int NLANES = DQ_W / LANE_W;
    localparam int CNT_W  = $clog2(BURST_LEN + 1);
    localparam int IDX_W  = BA_W + COL_BITS;
    localparam int DEPTH  = 1 << IDX_W;
    localparam logic [CNT_W-1:0] BL_CNT = CNT_W'(BURST_LEN);
    localparam logic [CNT_W-1:0] ONE_CNT = CNT_W'(1);

    // state registers
    logic                          cke_q;
    logic                          sref_q;
    dcd_pwr_t                      state_q;
    logic [BANKS-1:0]              open_q;
    logic [BANKS-1:0][ADDR_W-1:0]  mode_q;
    logic [CNT_W-1:0]              wr_left_q;
    logic [CNT_W-1:0]              rd_left_q;
    logic [BA_W-1:0]               wr_bank_q;
    logic [BA_W-1:0]               rd_bank_q;
    logic [COL_BITS-1:0]           wr_col_q;
    logic [COL_BITS-1:0]           rd_col_q;
    logic                          wr_ap_q;
    logic                          rd_ap_q;
    logic [DQ_W-1:0]               mem_q [DEPTH];

    // decode helpers
    logic [CMD_W-1:0]  code;
    logic [BA_W-1:0]   cmd_ba;
    logic [ADDR_W-1:0] cmd_addr;
    logic              awake;
    logic              dec_en;
    logic              sref_cmd;
    logic              low_entry;
    logic              sref_entry;
    logic              rtt_en;
    logic              wr_take;
    logic              wr_last;
    logic              rd_last;
    logic [IDX_W-1:0]  wr_idx;
    logic [DQ_W-1:0]   old_word;
    logic [DQ_W-1:0]   new_word;

    // all four strobes form one code
    assign code     = {cmd_pins_i.cs_n, cmd_pins_i.ras_n,
                       cmd_pins_i.cas_n, cmd_pins_i.we_n};
    assign cmd_ba   = cmd_pins_i.ba;
    assign cmd_addr = cmd_pins_i.addr;

    // pins only listened to while clocking runs and not powered down
    assign awake  = (state_q == PWR_ACTIVE) && !sref_q
                    && cke_q && cke_i;
    assign dec_en = awake && !cmd_pins_i.cs_n;

    // cke falling edge taken on the clock; refresh with it and all banks idle means self refresh
    assign sref_cmd   = (code == CMD_REFRESH) && (open_q == '0);
    assign low_entry  = (state_q == PWR_ACTIVE) && !sref_q
                        && cke_q && !cke_i;
    assign sref_entry = low_entry && sref_cmd;

    // termination enable kept in the extended mode word
    assign rtt_en = mode_q[EMR_SEL][RTT_LO_BIT] | mode_q[EMR_SEL][RTT_HI_BIT];

    // write beat bookkeeping
    assign wr_take  = wr_beat_i && (wr_left_q != '0) && awake;
    assign wr_last  = wr_take && (wr_left_q == ONE_CNT);
    assign rd_last  = rd_left_q == ONE_CNT;
    assign wr_idx   = {wr_bank_q, wr_col_q};
    assign old_word = mem_q[wr_idx];

    // one merge per byte lane, masks independent
    for (genvar g = 0; g < NLANES; g++)
    begin : g_lane
        dcd_lane_merge #(.W(LANE_W)) u_merge (
            .old_i    (old_word[g*LANE_W +: LANE_W]),
            .new_i    (dq_i[g*LANE_W +: LANE_W]),
            .mask_i   (dm_i[g]),
            .merged_o (new_word[g*LANE_W +: LANE_W])
        );
    end

    // registered cke gates internal clocking
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            cke_q <= 1'b0;
        else
            cke_q <= cke_i;
    end

    // self refresh: cke high clears it with no clock edge needed
    always_ff @(posedge clock_i or posedge sys_rst_i or posedge cke_i)
    begin
        if (sys_rst_i)
            sref_q <= 1'b0;
        else if (cke_i)
            sref_q <= 1'b0;
        else if (sref_entry)
            sref_q <= 1'b1;
    end

    // power-down states, chosen by bank state at entry
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            state_q <= PWR_ACTIVE;
        else
        begin
            case (state_q)
                PWR_ACTIVE:
                    if (low_entry && !sref_cmd)
                        state_q <= (|open_q) ? PWR_ACT_PD : PWR_PRE_PD;
                PWR_PRE_PD, PWR_ACT_PD:
                    if (cke_i)
                        state_q <= PWR_ACTIVE;
                default:
                    state_q <= PWR_ACTIVE;
            endcase
        end
    end

    // bank open state and rows; auto-close at burst end
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            open_q     <= '0;
            open_row_o <= '{default: ROW_RST};
        end
        else
        begin
            if (wr_last && wr_ap_q)
                open_q[wr_bank_q] <= 1'b0;
            if (rd_last && rd_ap_q)
                open_q[rd_bank_q] <= 1'b0;
            if (dec_en)
            begin
                case (code)
                    CMD_ACTIVE:
                    begin
                        open_q[cmd_ba]     <= 1'b1;
                        open_row_o[cmd_ba] <= cmd_addr;
                    end
                    CMD_PRECHARGE:
                        if (cmd_addr[AP_BIT])
                            open_q <= '0;
                        else
                            open_q[cmd_ba] <= 1'b0;
                    default: ;
                endcase
            end
        end
    end

    // mode registers: bank address selects, address is the op-code
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            mode_q <= '{default: MODE_RST};
        else if (dec_en && code == CMD_LOAD_MODE)
            mode_q[cmd_ba] <= cmd_addr;
    end

    // write burst tracking; a new write restarts the count
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            wr_left_q <= '0;
            wr_bank_q <= '0;
            wr_col_q  <= '0;
            wr_ap_q   <= 1'b0;
        end
        else if (dec_en && code == CMD_WRITE)
        begin
            wr_left_q <= BL_CNT;
            wr_bank_q <= cmd_ba;
            wr_col_q  <= cmd_addr[COL_BITS-1:0];
            wr_ap_q   <= cmd_addr[AP_BIT];
        end
        else if (wr_take)
        begin
            wr_left_q <= wr_left_q - ONE_CNT;
            wr_col_q  <= wr_col_q + COL_BITS'(1);
        end
    end

    // storage; masked lanes rewrite their old value
    always_ff @(posedge clock_i)
    begin
        if (wr_take)
            mem_q[wr_idx] <= new_word;
    end

    // read burst, one word per cycle on the data pins
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            rd_left_q <= '0;
            rd_bank_q <= '0;
            rd_col_q  <= '0;
            rd_ap_q   <= 1'b0;
            dq_o      <= '0;
            dq_oe_o   <= 1'b0;
        end
        else
        begin
            dq_oe_o <= rd_left_q != '0;
            dq_o    <= (rd_left_q != '0) ? mem_q[{rd_bank_q, rd_col_q}] : '0;
            if (dec_en && code == CMD_READ)
            begin
                rd_left_q <= BL_CNT;
                rd_bank_q <= cmd_ba;
                rd_col_q  <= cmd_addr[COL_BITS-1:0];
                rd_ap_q   <= cmd_addr[AP_BIT];
            end
            else if (rd_left_q != '0)
            begin
                rd_left_q <= rd_left_q - ONE_CNT;
                rd_col_q  <= rd_col_q + COL_BITS'(1);
            end
        end
    end

    // command echo and termination; odt is dead in self refresh
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            cmd_accept_o <= 1'b0;
            cmd_code_o   <= '0;
            odt_term_o   <= 1'b0;
        end
        else
        begin
            cmd_accept_o <= dec_en;
            cmd_code_o   <= dec_en ? code : cmd_code_o;
            odt_term_o   <= odt_i && rtt_en && !sref_q;
        end
    end

    // outputs straight from state flops
    assign clk_en_o       = cke_q;
    assign pwr_state_o    = state_q;
    assign self_refresh_o = sref_q;
    assign bank_open_o    = open_q;
    assign mode_reg_o     = mode_q;

    // checks, all on the one clock
    default clocking dcd_cb @(posedge clock_i);
    endclocking
    default disable iff (sys_rst_i);

    property p_cke_gate;
        !cke_i ##1 !cke_i |-> !clk_en_o && !cmd_accept_o;
    endproperty
    a_cke_gate: assert property (p_cke_gate)
        else $error("commands taken while cke low");

    property p_pd_entry;
        low_entry && !sref_cmd |=>
            pwr_state_o == (|$past(open_q) ? PWR_ACT_PD : PWR_PRE_PD);
    endproperty
    a_pd_entry: assert property (p_pd_entry)
        else $error("wrong power-down state");

    // async clear means cke high is never seen alongside self refresh
    property p_sref_exit;
        cke_i |-> !self_refresh_o;
    endproperty
    a_sref_exit: assert property (p_sref_exit)
        else $error("self refresh not left on cke high");

    property p_pd_ignore;
        pwr_state_o != PWR_ACTIVE |=> !cmd_accept_o && $stable(mode_reg_o);
    endproperty
    a_pd_ignore: assert property (p_pd_ignore)
        else $error("input honoured during power-down");

    property p_sref_ignore;
        self_refresh_o ##1 self_refresh_o |-> !odt_term_o && !cmd_accept_o;
    endproperty
    a_sref_ignore: assert property (p_sref_ignore)
        else $error("input honoured during self refresh");

    property p_cs_mask;
        cmd_pins_i.cs_n |=> !cmd_accept_o;
    endproperty
    a_cs_mask: assert property (p_cs_mask)
        else $error("command taken with select high");

    property p_cmd_code;
        dec_en |=> cmd_accept_o && cmd_code_o == $past(code);
    endproperty
    a_cmd_code: assert property (p_cmd_code)
        else $error("command code not echoed");

    property p_mask_keep;
        wr_take && (&dm_i) |=> mem_q[$past(wr_idx)] == $past(old_word);
    endproperty
    a_mask_keep: assert property (p_mask_keep)
        else $error("masked beat changed storage");

    property p_lane_split;
        wr_take && dm_i[0] && !dm_i[NLANES-1] |=>
            mem_q[$past(wr_idx)][LANE_W-1:0] == $past(old_word[LANE_W-1:0]);
    endproperty
    a_lane_split: assert property (p_lane_split)
        else $error("low lane written under its mask");

    property p_bank_act;
        dec_en && code == CMD_ACTIVE |=> bank_open_o[$past(cmd_ba)];
    endproperty
    a_bank_act: assert property (p_bank_act)
        else $error("activated bank not open");

    property p_mode_load;
        dec_en && code == CMD_LOAD_MODE |=>
            mode_reg_o[$past(cmd_ba)] == $past(cmd_addr);
    endproperty
    a_mode_load: assert property (p_mode_load)
        else $error("mode register not loaded");

    property p_pre_all;
        dec_en && code == CMD_PRECHARGE && cmd_addr[AP_BIT] |=>
            bank_open_o == '0;
    endproperty
    a_pre_all: assert property (p_pre_all)
        else $error("precharge all left a bank open");

    property p_odt_off;
        !rtt_en |=> !odt_term_o;
    endproperty
    a_odt_off: assert property (p_odt_off)
        else $error("termination with odt disabled");

    // main scenarios
    c_sref: cover property (sref_entry ##[1:20] !self_refresh_o);
    c_mask: cover property (wr_take && dm_i[0] ##1 wr_take);
    c_pre_all: cover property (dec_en && code == CMD_PRECHARGE
                               && cmd_addr[AP_BIT]);
    c_apd: cover property (pwr_state_o == PWR_ACT_PD);
endmodule
`default_nettype wire

/* test/dcd_ctrl_model.sv */
// Purpose : behavioural memory controller driving the decode inputs
// Assumes : tasks are called just after a falling clock edge
// Notes : single rank, so one chip select only
`timescale 1ns/1ps
`default_nettype none
module dcd_ctrl_model
    import dcd_pkg::*;
(
    // clock
    input  wire logic         clock_i,
    // pins toward the device
    output logic              cke_o,
    output logic              odt_o,
    output var dcd_cmd_pins_t cmd_o,
    output logic              wr_beat_o,
    output logic [15:0]       dq_o,
    output logic [1:0]        dm_o
);
    // power-up: cke low, deselected
    initial
    begin
        cke_o = 1'b0;
        odt_o = 1'b0;
        cmd_o = '1;
        wr_beat_o = 1'b0;
        dq_o = 16'h0000;
        dm_o = 2'h0;
    end

    // released data lines keep moving so no stale value looks valid
    always @(posedge clock_i)
        if (!wr_beat_o)
            dq_o <= ~dq_o;

    // all four strobes form one code
    task automatic put_cmd(input logic [3:0] code, input logic [1:0] ba,
                           input logic [12:0] addr);
        cmd_o = {code, ba, addr};
    endtask

    // one mask value travels with each beat
    task automatic put_beat(input logic on, input logic [15:0] d,
                            input logic [1:0] m);
        wr_beat_o = on;
        dq_o = on ? d : ~dq_o;
        dm_o = on ? m : ~dm_o;
    endtask

    // cke lowered only for a low-power entry
    task automatic set_cke(input logic v);
        cke_o = v;
    endtask

    task automatic set_odt(input logic v);
        odt_o = v;
    endtask
endmodule
`default_nettype wire

/* test/dcd_top_tb.sv */
// Purpose : self-checking bench for the ddr2 command/address decode
// Assumes : controller model drives pins just after falling edges
// Notes   : reference state kept in plain arrays, compared every result
`timescale 1ns/1ps
`default_nettype none
module dcd_top_tb;
    import dcd_pkg::*;
    localparam int BL = BURST_LEN_DEF;

    logic                   clock_i;
    logic                   sys_rst_i;
    logic                   cke;
    logic                   odt;
    dcd_cmd_pins_t          cmd;
    logic                   wr_beat;
    logic [15:0]            dq;
    logic [1:0]             dm;
    logic [15:0]            dq_o;
    logic                   dq_oe_o;
    logic                   clk_en_o;
    dcd_pwr_t               pwr_state_o;
    logic                   self_refresh_o;
    logic                   cmd_accept_o;
    logic [3:0]             cmd_code_o;
    logic [3:0]             bank_open_o;
    logic [3:0][12:0]       open_row_o;
    logic [3:0][12:0]       mode_reg_o;
    logic                   odt_term_o;
    int                     errors;
    int                     n_checks;
    logic [3:0]             exp_open;
    logic [3:0][12:0]       exp_row;
    logic [3:0][12:0]       exp_mode;
    logic [15:0]            mem [4][8];

    // 125 MHz clock
    initial
    begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end

    dcd_ctrl_model ctl_u (.clock_i(clock_i), .cke_o(cke), .odt_o(odt),
        .cmd_o(cmd), .wr_beat_o(wr_beat), .dq_o(dq), .dm_o(dm));

    dcd_top dut_u (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .cke_i(cke),
        .odt_i(odt), .cmd_pins_i(cmd), .wr_beat_i(wr_beat), .dq_i(dq),
        .dm_i(dm), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .clk_en_o(clk_en_o),
        .pwr_state_o(pwr_state_o), .self_refresh_o(self_refresh_o),
        .cmd_accept_o(cmd_accept_o), .cmd_code_o(cmd_code_o),
        .bank_open_o(bank_open_o), .open_row_o(open_row_o),
        .mode_reg_o(mode_reg_o), .odt_term_o(odt_term_o));

    task automatic end_sim;
        if (errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_rd(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR t=%0t rd got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_state;
        chk(bank_open_o, exp_open);
        chk(open_row_o, exp_row);
        chk(mode_reg_o, exp_mode);
    endtask

    // one command cycle, then deselect; model updated only if taken
    task automatic do_cmd(input logic [3:0] code, input logic [1:0] ba,
                          input logic [12:0] addr, input logic acc);
        @(negedge clock_i);
        ctl_u.put_cmd(code, ba, addr);
        @(negedge clock_i);
        ctl_u.put_cmd(4'hf, 2'h0, 13'h0000);
        chk(cmd_accept_o, acc);
        if (acc)
        begin
            chk(cmd_code_o, code);
            case (code)
                CMD_LOAD_MODE: exp_mode[ba] = addr;
                CMD_ACTIVE:
                begin
                    exp_open[ba] = 1'b1;
                    exp_row[ba] = addr;
                end
                CMD_PRECHARGE:
                    if (addr[AP_BIT])
                        exp_open = '0;
                    else
                        exp_open[ba] = 1'b0;
                default: ;
            endcase
        end
        chk_state();
    endtask

    // full burst with random idle gaps; masked bursts also auto-close
    task automatic wr_burst(input logic [1:0] ba, input logic [2:0] col,
                            input logic rnd);
        logic [15:0] d;
        logic [1:0]  m;
        do_cmd(CMD_WRITE, ba, {2'h0, rnd, 7'h00, col}, 1'b1);
        for (int i = 0; i < BL; i++)
        begin
            // idle cycle: moving data without a beat must be ignored
            if ($urandom % 2 == 1)
            begin
                ctl_u.put_beat(1'b0, 16'h0000, 2'h0);
                @(negedge clock_i);
            end
            d = 16'($urandom);
            m = rnd ? 2'($urandom) : 2'h0;
            ctl_u.put_beat(1'b1, d, m);
            for (int k = 0; k < 2; k++)
                if (!m[k])
                    mem[ba][3'(col + i)][k*8 +: 8] = d[k*8 +: 8];
            @(negedge clock_i);
        end
        ctl_u.put_beat(1'b0, 16'h0000, 2'h0);
        if (rnd)
            exp_open[ba] = 1'b0;
        chk(bank_open_o, exp_open);
    endtask

    // read burst; column wraps at the end of the eight-column array
    task automatic rd_burst(input logic [1:0] ba, input logic [2:0] col,
                            input logic ap);
        do_cmd(CMD_READ, ba, {2'h0, ap, 7'h00, col}, 1'b1);
        for (int w = 0; w < 6 && dq_oe_o !== 1'b1; w++)
            @(negedge clock_i);
        for (int i = 0; i < BL; i++)
        begin
            chk(dq_oe_o, 1'b1);
            chk_rd(dq_o, mem[ba][3'(col + i)]);
            @(negedge clock_i);
        end
        chk(dq_oe_o, 1'b0);
        if (ap)
            exp_open[ba] = 1'b0;
        repeat (2) @(negedge clock_i);
        chk(bank_open_o, exp_open);
    endtask

    // hang guard, far beyond the hundred or fewer cycles needed
    initial
    begin
        #80000;
        errors++;
        end_sim();
    end

    // main sequence
    initial
    begin
        errors = 0;
        n_checks = 0;
        exp_open = '0;
        exp_row = '0;
        exp_mode = '0;
        foreach (mem[b, c])
            mem[b][c] = 'x;
        void'($urandom(93));
        sys_rst_i = 1'b1;
        repeat (4) @(posedge clock_i);
        @(negedge clock_i);
        sys_rst_i = 1'b0;
        ctl_u.set_cke(1'b1);
        chk_state();
        repeat (2) @(negedge clock_i);
        for (int b = 0; b < 4; b++)
            do_cmd(CMD_LOAD_MODE, 2'(b), 13'($urandom), 1'b1);
        do_cmd(CMD_ACTIVE | 4'h8, 2'h1, 13'h1abc, 1'b0);
        for (int b = 0; b < 4; b++)
            do_cmd(CMD_ACTIVE, 2'(b), 13'($urandom), 1'b1);
        do_cmd(CMD_REFRESH, 2'h0, 13'h0000, 1'b1);
        wr_burst(2'h2, 3'h6, 1'b0);
        wr_burst(2'h2, 3'h6, 1'b1);
        rd_burst(2'h2, 3'h6, 1'b1);
        do_cmd(CMD_PRECHARGE, 2'h0, 13'h0000, 1'b1);
        do_cmd(CMD_PRECHARGE, 2'h1, 13'h0400, 1'b1);
        // termination enable bits in the extended register
        do_cmd(CMD_LOAD_MODE, EMR_SEL, 13'h0004, 1'b1);
        ctl_u.set_odt(1'b1);
        repeat (2) @(negedge clock_i);
        chk(odt_term_o, 1'b1);
        do_cmd(CMD_LOAD_MODE, EMR_SEL, 13'h0000, 1'b1);
        repeat (2) @(negedge clock_i);
        chk(odt_term_o, 1'b0);
        do_cmd(CMD_LOAD_MODE, EMR_SEL, 13'h0040, 1'b1);
        repeat (2) @(negedge clock_i);
        chk(odt_term_o, 1'b1);
        // active power-down with a row open
        do_cmd(CMD_ACTIVE, 2'h3, 13'h1555, 1'b1);
        ctl_u.set_cke(1'b0);
        @(negedge clock_i);
        chk(clk_en_o, 1'b0);
        chk(pwr_state_o, PWR_ACT_PD);
        do_cmd(CMD_PRECHARGE, 2'h3, 13'h0400, 1'b0);
        chk(odt_term_o, 1'b1);
        ctl_u.set_cke(1'b1);
        @(negedge clock_i);
        chk(pwr_state_o, PWR_ACTIVE);
        chk(clk_en_o, 1'b1);
        do_cmd(CMD_PRECHARGE, 2'h3, 13'h0400, 1'b1);
        // self refresh entry with all banks idle
        @(negedge clock_i);
        ctl_u.put_cmd(CMD_REFRESH, 2'h0, 13'h0000);
        ctl_u.set_cke(1'b0);
        @(negedge clock_i);
        ctl_u.put_cmd(4'hf, 2'h0, 13'h0000);
        chk(self_refresh_o, 1'b1);
        do_cmd(CMD_ACTIVE, 2'h0, 13'h0000, 1'b0);
        chk(odt_term_o, 1'b0);
        // exit away from any clock edge
        @(posedge clock_i);
        #2;
        ctl_u.set_cke(1'b1);
        #1;
        chk(self_refresh_o, 1'b0);
        // precharge power-down with a deselected bus
        repeat (3) @(negedge clock_i);
        ctl_u.set_cke(1'b0);
        @(negedge clock_i);
        chk(pwr_state_o, PWR_PRE_PD);
        ctl_u.set_cke(1'b1);
        @(negedge clock_i);
        chk(pwr_state_o, PWR_ACTIVE);
        do_cmd(CMD_ACTIVE, 2'h1, 13'h0abc, 1'b1);
        end_sim();
    end
endmodule
`default_nettype wire
